// ===== hdl/fbx_exchange.sv
// fieldbus slave data exchange: command intake, fault latch, response packet
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "fbx_params.svh"
module fbx_exchange #(
    parameter int unsigned SLOW_CYC = `FBX_SLOW_CYC,
    parameter int unsigned FAST_CYC = `FBX_FAST_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // device side
    input wire logic link_error,
    input wire logic link_ready,
    output logic output_enable,
    output logic bus_fault,
    output logic cmd_valid,
    output fbx_pkg::cmd_pkt_t cmd_out,
    output logic irq
);
    import fbx_pkg::*;

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic ap_wr_q, ap_wr_d;
    // reads decode in the address phase so hrdata already stands in the data phase
    logic rd_take;
    logic [11:0] ap_addr_q, ap_addr_d;

    always_comb
    begin
        ap_wr_d = hsel && hready && htrans[1] && hwrite;
        rd_take = hsel && hready && htrans[1] && !hwrite;
        ap_addr_d = (hsel && hready) ? haddr[11:0] : ap_addr_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 12'h000;
        end
        else
        begin
            ap_wr_q <= ap_wr_d;
            ap_addr_q <= ap_addr_d;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // data is staged first; writing a non-null code to the code register launches the packet
    logic [23:0] data_q, data_d;
    logic [7:0] sense_q, sense_d;
    logic [15:0] deliv_q, deliv_d;
    logic [31:0] fwdref_q, fwdref_d;
    logic [2:0] mask_q, mask_d;
    logic cmd_wr;
    logic [7:0] cmd_code;

    always_comb
    begin
        data_d = data_q;
        sense_d = sense_q;
        deliv_d = deliv_q;
        fwdref_d = fwdref_q;
        mask_d = mask_q;
        cmd_wr = 1'b0;
        cmd_code = hwdata[7:0];
        if (ap_wr_q)
        begin
            case (ap_addr_q)
                `FBX_OFF_CMD: cmd_wr = 1'b1;
                `FBX_OFF_DATA: data_d = hwdata[23:0];
                `FBX_OFF_SENSE: sense_d = hwdata[7:0];
                `FBX_OFF_DELIV: deliv_d = hwdata[15:0];
                `FBX_OFF_FWDREF: fwdref_d = hwdata;
                `FBX_OFF_IRQ_MASK: mask_d = hwdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_q <= 24'h00_0000;
            sense_q <= 8'h00;
            deliv_q <= 16'h0000;
            fwdref_q <= 32'h0000_0000;
            mask_q <= 3'h0;
        end
        else
        begin
            data_q <= data_d;
            sense_q <= sense_d;
            deliv_q <= deliv_d;
            fwdref_q <= fwdref_d;
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------
    // command intake and fault latch
    // ------------------------------------------------------------
    flt_state_t st_q, st_d;
    logic cmd_valid_d;
    cmd_pkt_t cmd_out_d;
    logic [7:0] last_cmd_q, last_cmd_d;
    logic live_cmd;
    logic clear_cmd;

    always_comb
    begin
        live_cmd = cmd_wr && (cmd_code != `FBX_CMD_NULL);
        clear_cmd = live_cmd && (cmd_code == `FBX_CMD_CLEAR);
        cmd_valid_d = live_cmd;
        cmd_out_d = live_cmd ? {cmd_code, data_q} : cmd_out;
        last_cmd_d = live_cmd ? cmd_code : last_cmd_q;
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (link_ready) st_d = ST_RUN;
            ST_RUN: if (link_error) st_d = ST_FAULT;
            // a fresh error in the clear cycle keeps the fault set
            ST_FAULT: if (clear_cmd && !link_error) st_d = ST_RUN;
            default: st_d = ST_IDLE;
        endcase
        if (st_q == ST_IDLE && link_error)
        begin
            st_d = ST_FAULT;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= ST_IDLE;
            cmd_valid <= 1'b0;
            cmd_out <= '0;
            last_cmd_q <= 8'h00;
            output_enable <= 1'b0;
            bus_fault <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cmd_valid <= cmd_valid_d;
            cmd_out <= cmd_out_d;
            last_cmd_q <= last_cmd_d;
            output_enable <= (st_d == ST_RUN);
            bus_fault <= (st_d == ST_FAULT);
        end
    end

    // ------------------------------------------------------------
    // response refresh
    // ------------------------------------------------------------
    logic slow_tick, fast_tick;

    fbx_tick #(.PERIOD(SLOW_CYC)) u_slow (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(slow_tick)
    );

    fbx_tick #(.PERIOD(FAST_CYC)) u_fast (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(fast_tick)
    );

    logic toggle_q, toggle_d;
    logic [15:0] status_now;
    sense_t sense_live;
    resp_pkt_t resp_q, resp_d;

    always_comb
    begin
        sense_live = sense_q;
        // toggle freezes while the link is down or faulted
        toggle_d = toggle_q ^ (slow_tick && st_q == ST_RUN);
    end

    fbx_status u_status (
        .sense(sense_live),
        .toggle(toggle_q),
        .bus_fault(bus_fault),
        .word(status_now)
    );

    always_comb
    begin
        resp_d = resp_q;
        if (slow_tick)
        begin
            // whole word captured in one cycle; between captures a fast tick refreshes output_on alone
            resp_d.status = status_now;
            resp_d.deliv = deliv_q;
            resp_d.fwd = fwdref_q[15:0];
            resp_d.refl = fwdref_q[31:16];
            resp_d.data = {16'h0000, data_q};
            resp_d.defn = last_cmd_q;
        end
        else if (fast_tick)
        begin
            resp_d.status[`FBX_ST_OUTON] = status_now[`FBX_ST_OUTON];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            toggle_q <= 1'b0;
            resp_q <= '0;
        end
        else
        begin
            toggle_q <= toggle_d;
            resp_q <= resp_d;
        end
    end

    // ------------------------------------------------------------
    // interrupts and read data
    // ------------------------------------------------------------
    logic [2:0] ist_q, ist_d;
    logic [31:0] rdata_d;
    logic [2:0] ev;

    always_comb
    begin
        ev = 3'h0;
        ev[`FBX_IRQ_CMD] = live_cmd;
        ev[`FBX_IRQ_FAULT] = (st_d == ST_FAULT) && (st_q != ST_FAULT);
        ev[`FBX_IRQ_REFRESH] = slow_tick;
        rdata_d = `FBX_RESET_WORD;
        ist_d = ist_q;
        if (rd_take)
        begin
            // next values forward a write whose data phase shares this cycle
            case (haddr[11:0])
                `FBX_OFF_CMD: rdata_d = {24'h00_0000, last_cmd_d};
                `FBX_OFF_DATA: rdata_d = {8'h00, data_d};
                `FBX_OFF_CTRL: rdata_d = {29'h0, toggle_q, bus_fault, output_enable};
                `FBX_OFF_SENSE: rdata_d = {24'h00_0000, sense_d};
                `FBX_OFF_DELIV: rdata_d = {16'h0000, deliv_d};
                `FBX_OFF_FWDREF: rdata_d = fwdref_d;
                // packet byte n in lane n % 4; first status byte is bits 15:8
                `FBX_OFF_RESP0: rdata_d = {resp_q.deliv, resp_q.status[7:0],
                    resp_q.status[15:8]};
                `FBX_OFF_RESP1: rdata_d = {resp_q.refl, resp_q.fwd};
                `FBX_OFF_RESP2: rdata_d = resp_q.data[31:0];
                `FBX_OFF_RESP3: rdata_d = {16'h0000, resp_q.defn, resp_q.data[39:32]};
                `FBX_OFF_IRQ_STAT:
                begin
                    rdata_d = {29'h0, ist_q};
                    ist_d = 3'h0;
                end
                `FBX_OFF_IRQ_MASK: rdata_d = {29'h0, mask_d};
                default: rdata_d = `FBX_RESET_WORD;
            endcase
        end
        ist_d = ist_d | ev;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ist_q <= 3'h0;
            hrdata <= 32'h0000_0000;
            irq <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            hrdata <= rdata_d;
            irq <= |(ist_d & mask_q);
        end
    end

    always_comb
    begin
        hreadyout = 1'b1;
        hresp = 1'b0;
    end
endmodule

// ===== hdl/fbx_params.svh
// constants of the fieldbus data exchange block
`ifndef FBX_PARAMS_SVH
`define FBX_PARAMS_SVH

// register byte offsets
`define FBX_OFF_CMD       12'h000
`define FBX_OFF_DATA      12'h004
`define FBX_OFF_CTRL      12'h008
`define FBX_OFF_SENSE     12'h00C
`define FBX_OFF_DELIV     12'h010
`define FBX_OFF_FWDREF    12'h014
`define FBX_OFF_RESP0     12'h018
`define FBX_OFF_RESP1     12'h01C
`define FBX_OFF_RESP2     12'h020
`define FBX_OFF_RESP3     12'h024
`define FBX_OFF_IRQ_STAT  12'h028
`define FBX_OFF_IRQ_MASK  12'h02C

// command codes
`define FBX_CMD_NULL      8'h00
`define FBX_CMD_CLEAR     8'h77

// status bit positions within the 16-bit status word
`define FBX_ST_MODE_LO    8
`define FBX_ST_MODE_HI    9
`define FBX_ST_SETPT      10
`define FBX_ST_EOL        12
`define FBX_ST_TOGGLE     13
`define FBX_ST_BUSFLT     14
`define FBX_ST_OVTEMP     1
`define FBX_ST_ILOCK      2
`define FBX_ST_PWRFAIL    3
`define FBX_ST_CONTACT    5
`define FBX_ST_OUTON      7

// refresh timing
`define FBX_CLK_HZ        25000000
`define FBX_SLOW_MS       100
`define FBX_FAST_MS       20
`define FBX_SLOW_CYC      (`FBX_CLK_HZ / 1000 * `FBX_SLOW_MS)
`define FBX_FAST_CYC      (`FBX_CLK_HZ / 1000 * `FBX_FAST_MS)

// interrupt status bits
`define FBX_IRQ_CMD       0
`define FBX_IRQ_FAULT     1
`define FBX_IRQ_REFRESH   2

`define FBX_RESET_WORD    32'h0000_0000
`endif

// ===== hdl/fbx_pkg.sv
// types shared by the fieldbus data exchange block
package fbx_pkg;
    typedef struct packed {
        logic [7:0] code;
        logic [23:0] data;
    } cmd_pkt_t;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] deliv;
        logic [15:0] fwd;
        logic [15:0] refl;
        logic [39:0] data;
        logic [7:0] defn;
    } resp_pkt_t;

    typedef struct packed {
        logic setpt_ok;
        logic target_life_ended;
        logic ovtemp;
        logic ilock_open;
        logic pwr_fail;
        logic contactor_open;
        logic output_on;
        logic bus_ctrl;
    } sense_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b100
    } flt_state_t;
endpackage

// ===== hdl/fbx_status.sv
// assembles the 16-bit status word with reserved bits forced to zero
`timescale 1ns/1ps
`include "fbx_params.svh"
module fbx_status (
    // inputs
    input wire fbx_pkg::sense_t sense,
    input wire logic toggle,
    input wire logic bus_fault,
    // word out
    output logic [15:0] word
);
    import fbx_pkg::*;

    always_comb
    begin
        word = 16'h0000;
        word[`FBX_ST_MODE_HI] = sense.bus_ctrl;
        word[`FBX_ST_MODE_LO] = 1'b0;
        word[`FBX_ST_SETPT] = sense.setpt_ok;
        word[`FBX_ST_EOL] = sense.target_life_ended;
        word[`FBX_ST_TOGGLE] = toggle;
        word[`FBX_ST_BUSFLT] = bus_fault;
        word[`FBX_ST_OVTEMP] = sense.ovtemp;
        word[`FBX_ST_ILOCK] = sense.ilock_open;
        word[`FBX_ST_PWRFAIL] = sense.pwr_fail;
        word[`FBX_ST_CONTACT] = sense.contactor_open;
        word[`FBX_ST_OUTON] = sense.output_on;
    end
endmodule

// ===== hdl/fbx_tick.sv
// free-running period counter giving a one-cycle tick
`timescale 1ns/1ps
`include "fbx_params.svh"
module fbx_tick #(
    parameter int unsigned PERIOD = 100
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // tick out
    output logic tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;

    always_comb
    begin
        tick_d = (cnt_q == 32'(PERIOD - 1));
        cnt_d = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule

// ===== tb/fbx_exchange_monitor.sv
// assertion checker for the fieldbus data exchange block
`timescale 1ns/1ps
module fbx_exchange_monitor #(
    parameter int unsigned SLOW_CYC = 40,
    parameter int unsigned FAST_CYC = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // device side
    input wire logic link_error,
    input wire logic link_ready,
    input wire logic output_enable,
    input wire logic bus_fault,
    input wire logic cmd_valid,
    input wire fbx_pkg::cmd_pkt_t cmd_out,
    input wire logic irq
);
    import fbx_pkg::*;
    logic take;
    logic wr_cmd;
    logic rd_resp0;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    assign take = hsel && hready && htrans[1];
    assign wr_cmd = take && hwrite && (haddr[11:0] == 12'h000);
    assign rd_resp0 = take && !hwrite && (haddr[11:0] == 12'h018);

    AST_FAULT_SET: assert property (link_error |=> bus_fault && !output_enable)
        else $error("link error did not latch fault");
    AST_FAULT_CAUSE: assert property ($rose(bus_fault) |-> $past(link_error))
        else $error("fault rose without link error");
    AST_OE_OFF: assert property (bus_fault |-> !output_enable)
        else $error("output on during fault");
    AST_FAULT_CLR: assert property ($fell(bus_fault) |-> cmd_valid && cmd_out.code == 8'h77)
        else $error("fault left without clear command");
    AST_CLR_WORKS: assert property (wr_cmd ##1 (hwdata[7:0] == 8'h77 && !link_error)
        |=> !bus_fault)
        else $error("clear command did not drop fault");
    AST_NULL: assert property (cmd_valid |-> cmd_out.code != 8'h00)
        else $error("null command produced a pulse");
    AST_CMD_TAKE: assert property (wr_cmd ##1 hwdata[7:0] != 8'h00
        |=> cmd_valid && cmd_out.code == $past(hwdata[7:0]))
        else $error("command not taken at once");
    AST_CMD_HOLD: assert property (!cmd_valid |-> $stable(cmd_out))
        else $error("command output moved without pulse");
    AST_RESV: assert property (rd_resp0 |=> (hrdata[3] | hrdata[7] | hrdata[8]
        | hrdata[12] | hrdata[14]) == 1'b0)
        else $error("reserved status bit set");

    AST_RESP_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");

    cover property (wr_cmd ##1 hwdata[7:0] == 8'h77);
    cover property ($rose(bus_fault));
    cover property ($rose(irq));
endmodule

bind fbx_exchange fbx_exchange_monitor #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC))
    i_fbx_exchange_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_error(link_error),
    .link_ready(link_ready), .output_enable(output_enable), .bus_fault(bus_fault),
    .cmd_valid(cmd_valid), .cmd_out(cmd_out), .irq(irq));

// ===== tb/fbx_exchange_tb_top.sv
// self-checking testbench of the fieldbus data exchange block
`timescale 1ns/1ps
module fbx_exchange_tb_top;
    import fbx_pkg::*;
    localparam int SLOW = 40;
    localparam int FAST = 8;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic link_error, link_ready, output_enable, bus_fault, cmd_valid, irq, t;
    cmd_pkt_t cmd_out;
    int failures, n_tests;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, g); end end

    fbx_exchange #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) i_fbx_exchange (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link_error(link_error), .link_ready(link_ready),
        .output_enable(output_enable), .bus_fault(bus_fault), .cmd_valid(cmd_valid),
        .cmd_out(cmd_out), .irq(irq));
    fbx_link_model i_fbx_link_model (.hclk(hclk), .hresetn(hresetn),
        .link_ready(link_ready), .link_error(link_error));

    // ----
    // bus tasks
    // ----
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
        input string n);
        ahb(1'b0, a, 32'h0);
        `CHK(n, e, rd & m)
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        failures++;
        print_verdict();
    end

    // ----
    // scenarios
    // ----
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(12'h018, 32'hFFFF_FFFF, 32'h0, "resp0 before refresh");
        repeat (30) @(posedge hclk);
        ahb(1'b1, 12'h000, 32'h77);
        repeat (2) @(posedge hclk);
        `CHK("output on", 1'b1, output_enable)
        ahb(1'b1, 12'h004, 32'h0012_3456);
        ahb(1'b1, 12'h000, 32'h00);
        rdc(12'h000, 32'hFFFF_FFFF, 32'h0000_0077, "last cmd");
        ahb(1'b1, 12'h000, 32'h21);
        @(posedge hclk);
        `CHK("cmd out", 32'h2112_3456, cmd_out)
        ahb(1'b1, 12'h010, 32'h1234);
        ahb(1'b1, 12'h014, 32'hBEEF_0A0B);
        ahb(1'b1, 12'h00C, 32'hFF);
        repeat (2 * SLOW) @(posedge hclk);
        rdc(12'h018, 32'hFFFF_FFDF, 32'h1234_AE16, "resp0");
        t = rd[5];
        // address phases exactly SLOW cycles apart see exactly one capture
        repeat (SLOW - 3) @(posedge hclk);
        rdc(12'h018, 32'h20, t ? 32'h0 : 32'h20, "toggle");
        rdc(12'h01C, 32'hFFFF_FFFF, 32'hBEEF_0A0B, "resp1");
        rdc(12'h020, 32'hFFFF_FFFF, 32'h0012_3456, "resp2");
        rdc(12'h024, 32'hFFFF_FFFF, 32'h0000_2100, "resp3");
        // output_on and bus_ctrl low, other flags high
        ahb(1'b1, 12'h00C, 32'hFC);
        repeat (FAST + 4) @(posedge hclk);
        rdc(12'h018, 32'h8000, 32'h0, "output on flag");
        repeat (SLOW) @(posedge hclk);
        rdc(12'h018, 32'h3, 32'h0, "mode user");
        // interrupt: unmasked command, then the mask is cleared again
        ahb(1'b1, 12'h02C, 32'h1);
        ahb(1'b0, 12'h028, 32'h0);
        ahb(1'b1, 12'h000, 32'h33);
        repeat (2) @(posedge hclk);
        `CHK("irq", 1'b1, irq)
        rdc(12'h028, 32'h1, 32'h1, "irq status");
        @(posedge hclk);
        `CHK("irq cleared", 1'b0, irq)
        ahb(1'b1, 12'h02C, 32'h0);
        rdc(12'h0FC, 32'hFFFF_FFFF, 32'h0, "unmapped");
        // fault while running, refused clear by other code, then clear
        i_fbx_link_model.inject(3);
        @(posedge hclk);
        `CHK("fault", 2'b10, {bus_fault, output_enable})
        ahb(1'b1, 12'h000, 32'h21);
        rdc(12'h008, 32'h3, 32'h2, "ctrl in fault");
        repeat (SLOW + 2) @(posedge hclk);
        rdc(12'h018, 32'h40, 32'h40, "bus fault flag");
        t = rd[5];
        repeat (SLOW) @(posedge hclk);
        rdc(12'h018, 32'h20, t ? 32'h20 : 32'h0, "toggle frozen");
        ahb(1'b1, 12'h000, 32'h77);
        @(posedge hclk);
        `CHK("cleared", 2'b01, {bus_fault, output_enable})
        print_verdict();
    end
endmodule

// ===== tb/fbx_link_model.sv
// fieldbus link model: ready after baud settle, error bursts on request
`timescale 1ns/1ps
module fbx_link_model #(
    parameter int unsigned SETTLE = 20
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link status
    output logic link_ready,
    output logic link_error
);
    initial
    begin
        link_ready = 1'b0;
        link_error = 1'b0;
        @(posedge hresetn);
        // auto-baud search delays readiness
        repeat (SETTLE) @(posedge hclk);
        link_ready <= 1'b1;
    end

    task automatic inject(input int n);
        @(posedge hclk);
        link_error <= 1'b1;
        repeat (n) @(posedge hclk);
        link_error <= 1'b0;
    endtask
endmodule
